// file: src/irq_status_pkg.sv
// Constants for the interrupt status, mask and collision position block.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
package irq_status_pkg;

  // Register indices and their byte addresses (index times four)
  localparam logic [7:0] IDX_PROTOCOL = 8'h01;
  localparam logic [7:0] IDX_NORESP = 8'h07;
  localparam logic [7:0] IDX_REGULATOR = 8'h0b;
  localparam logic [7:0] IDX_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_MASK = 8'h0d;
  localparam logic [7:0] IDX_COLPOS = 8'h0e;
  localparam logic [7:0] ADDR_PROTOCOL = {IDX_PROTOCOL[5:0], 2'b00};
  localparam logic [7:0] ADDR_NORESP = {IDX_NORESP[5:0], 2'b00};
  localparam logic [7:0] ADDR_REGULATOR = {IDX_REGULATOR[5:0], 2'b00};
  localparam logic [7:0] ADDR_FLAGS = {IDX_FLAGS[5:0], 2'b00};
  localparam logic [7:0] ADDR_MASK = {IDX_MASK[5:0], 2'b00};
  localparam logic [7:0] ADDR_COLPOS = {IDX_COLPOS[5:0], 2'b00};

  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h3e;
  localparam logic [7:0] COLPOS_RST = 8'h00;
  localparam logic [7:0] REGULATOR_RST = 8'h87;
  localparam logic [7:0] PROTOCOL_RST = 8'h00;
  localparam logic [7:0] NORESP_RST = 8'h00;
  localparam logic [1:0] HEADROOM_RST = 2'b11;

  // Flag bit positions
  localparam int FLAG_TX = 7;
  localparam int FLAG_RX = 6;
  localparam int FLAG_FIFO = 5;
  localparam int FLAG_CRC = 4;
  localparam int FLAG_PARITY = 3;
  localparam int FLAG_FRAMING = 2;
  localparam int FLAG_COLL = 1;
  localparam int FLAG_NORESP = 0;
  localparam logic [7:0] TX_ALLOWED = 8'ha0;
  localparam logic [7:0] RX_ALLOWED = 8'h40;
  localparam logic [7:0] ALL_ALLOWED = 8'hff;

  // Protocol control fields
  localparam int PROTO_SKIP_CRC = 7;
  localparam int PROTO_COLL_SEVEN = 5;
  localparam logic [4:0] ISO_A_CODE = 5'h08;

  // Regulator control fields and headroom codes
  localparam int REG_AUTO = 7;
  localparam int VSET_MSB = 2;
  localparam logic [1:0] HEADROOM_250 = 2'b11;
  localparam logic [1:0] HEADROOM_350 = 2'b10;
  localparam logic [1:0] HEADROOM_400 = 2'b00;
  localparam logic [1:0] HEADROOM_RESERVED = 2'b01;

  // FIFO thresholds and collision counting
  localparam int FIFO_RX_HIGH = 8;
  localparam int FIFO_TX_LOW = 4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int COLL_RATE_KBPS = 106;
  localparam int COLL_WINDOW_CYCLES =
    1000000 / (COLL_RATE_KBPS * CLK_PERIOD_NS);
  localparam logic [3:0] COLL_THRESH_SIX = 4'h6;
  localparam logic [3:0] COLL_THRESH_SEVEN = 4'h7;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [0:0] {
    NR_IDLE = 1'b0,
    NR_WAIT = 1'b1
  } noresp_state_e;

endpackage

// file: src/irq_status_collision.sv
// Interrupt flags, interrupt mask, collision position and regulator
// headroom selection, reached over AXI4-Lite.
// Assumes decoder, encoder and FIFO events arrive synchronous to aclk.
//
// Decided for this implementation: the AXI4-Lite slave port.

// Behaviour
// - Flags clear at reset, enable low, and any protocol register write.
// - Reading the flag register clears it and drops the interrupt line.
// - During transmit the decoder is off; only flags 7 and 5 change.
// - During receive only flag 6 changes, without raising the line.
// - Interrupt line rises at end of transmit or receive phase.
// - Flag 7 sets at transmit start; interrupt follows transmit end.
// - Flag 6 sets at start of frame; interrupt follows receive end.
// - Flag 5 sets on FIFO above 8 in receive, below 4 in transmit.
// - Flag 4 sets on receive CRC error unless CRC checking is skipped.
// - Flag 3 sets on parity error in type A reception.
// - Flag 2 sets on byte framing or end-of-frame error.
// - Flag 1 sets on more than 6 or 7 events within one bit period in type A.
// - Flag 0 sets when no response arrives within programmed wait.
// - Mask resets to 0x3e; no-response enable defaults to zero.
// - Mask bits 5 to 0 let matching flags raise the interrupt line.
// - Mask bits 7 and 6 hold upper collision position, cleared on read.
// - Position register holds low eight bits, resets zero, clears on read.
// - Automatic regulator: code 11, 10, 00 selects 250, 350, 400 mV.
// - Manual regulator uses the three voltage set bits, bit 2 MSB.
module irq_status_collision
  import irq_status_pkg::*;
#(
  parameter int FIFO_CNT_W = 5,
  parameter int NORESP_STEP_CYCLES = 500
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Device enable pin, low clears the device registers
  input wire logic enable,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Link phase and decoder events
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic sof_detected,
  input wire logic [FIFO_CNT_W-1:0] fifo_level,
  input wire logic crc_error,
  input wire logic parity_error,
  input wire logic framing_error,
  input wire logic collision_event,
  input wire logic [9:0] bit_position,
  // Interrupt and status outputs
  output logic irq,
  output logic decoder_enable,
  output logic [9:0] collision_position,
  // Regulator control
  output logic regulator_auto,
  output logic [1:0] headroom_sel,
  output logic [2:0] manual_level
);

  localparam logic [10:0] COLL_WIN_LAST = 11'(COLL_WINDOW_CYCLES - 1);
  localparam logic [15:0] STEP_LAST = 16'(NORESP_STEP_CYCLES - 1);

  // Register file
  logic [7:0] protocol;
  logic [7:0] noresp_wait;
  logic [7:0] regulator;
  logic [7:0] flags;
  logic [7:0] mask;
  logic [7:0] colpos;
  logic [1:0] headroom;
  logic [7:0] pending;
  logic irq_q;

  // Bus state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;

  // Event history
  logic tx_d;
  logic rx_d;
  logic fifo_cond_d;
  logic coll_active;
  logic [10:0] coll_win;
  logic [3:0] coll_cnt;
  noresp_state_e nr_state;
  noresp_state_e next_nr_state;
  logic [15:0] nr_step;
  logic [7:0] nr_unit;

  // Device-side clear: reset or enable pin low
  wire dev_clear = ~aresetn | ~enable;

  // Write path decode
  wire wr_go = aw_held & w_held & ~bvalid;
  wire wr_en = wr_go & w_lane0_q;
  wire wr_proto = wr_en & (aw_addr_q[7:2] == ADDR_PROTOCOL[7:2]);
  wire wr_noresp = wr_en & (aw_addr_q[7:2] == ADDR_NORESP[7:2]);
  wire wr_reg = wr_en & (aw_addr_q[7:2] == ADDR_REGULATOR[7:2]);
  wire wr_mask = wr_en & (aw_addr_q[7:2] == ADDR_MASK[7:2]);
  wire wr_known = (aw_addr_q[7:2] == ADDR_PROTOCOL[7:2])
    | (aw_addr_q[7:2] == ADDR_NORESP[7:2])
    | (aw_addr_q[7:2] == ADDR_REGULATOR[7:2])
    | (aw_addr_q[7:2] == ADDR_FLAGS[7:2])
    | (aw_addr_q[7:2] == ADDR_MASK[7:2])
    | (aw_addr_q[7:2] == ADDR_COLPOS[7:2]);

  // Read path decode
  wire rd_take = arvalid & ~rvalid;
  wire rd_proto = araddr[7:2] == ADDR_PROTOCOL[7:2];
  wire rd_noresp = araddr[7:2] == ADDR_NORESP[7:2];
  wire rd_reg = araddr[7:2] == ADDR_REGULATOR[7:2];
  wire rd_flags = araddr[7:2] == ADDR_FLAGS[7:2];
  wire rd_mask = araddr[7:2] == ADDR_MASK[7:2];
  wire rd_colpos = araddr[7:2] == ADDR_COLPOS[7:2];
  wire rd_known = rd_proto | rd_noresp | rd_reg | rd_flags | rd_mask
    | rd_colpos;
  wire [7:0] rd_byte = ({8{rd_proto}} & protocol)
    | ({8{rd_noresp}} & noresp_wait)
    | ({8{rd_reg}} & regulator)
    | ({8{rd_flags}} & flags)
    | ({8{rd_mask}} & mask)
    | ({8{rd_colpos}} & colpos);

  // Clearing by read happens as the read is taken, so the captured
  // data and the cleared state can never disagree.
  wire flags_read = rd_take & rd_flags;
  wire mask_read = rd_take & rd_mask;
  wire colpos_read = rd_take & rd_colpos;

  // Protocol decode
  wire iso_a = protocol[4:0] == ISO_A_CODE;
  wire skip_crc = protocol[PROTO_SKIP_CRC];
  wire [3:0] coll_thresh = protocol[PROTO_COLL_SEVEN] ?
    COLL_THRESH_SEVEN : COLL_THRESH_SIX;

  // Phase tracking
  wire tx_start = tx_active & ~tx_d;
  wire tx_end = ~tx_active & tx_d;
  wire rx_end = ~rx_active & rx_d;
  wire phase_end = tx_end | rx_end;
  wire in_phase = tx_active | rx_active;
  wire [7:0] allowed = tx_active ? TX_ALLOWED :
    (rx_active ? RX_ALLOWED : ALL_ALLOWED);

  // FIFO threshold condition, flagged on its rising edge
  wire fifo_cond =
    (rx_active & (fifo_level > FIFO_CNT_W'(FIFO_RX_HIGH)))
    | (tx_active & (fifo_level < FIFO_CNT_W'(FIFO_TX_LOW)));
  wire fifo_hit = fifo_cond & ~fifo_cond_d;

  // Collision counting inside one 106 kbps bit period
  wire coll_win_done = coll_active & (coll_win == COLL_WIN_LAST);
  wire coll_hit = iso_a & coll_active & collision_event
    & (coll_cnt == coll_thresh);

  // No-response timing
  wire nr_abort = sof_detected | rx_active | tx_active;
  wire nr_step_done = nr_step == STEP_LAST;
  wire noresp_hit = (nr_state == NR_WAIT) & ~nr_abort & nr_step_done
    & (nr_unit == noresp_wait - 8'h01);

  // Event vector in flag bit order
  logic [7:0] event_set;
  assign event_set[FLAG_TX] = tx_start;
  assign event_set[FLAG_RX] = sof_detected;
  assign event_set[FLAG_FIFO] = fifo_hit;
  assign event_set[FLAG_CRC] = crc_error & ~skip_crc;
  assign event_set[FLAG_PARITY] = parity_error & iso_a;
  assign event_set[FLAG_FRAMING] = framing_error;
  assign event_set[FLAG_COLL] = coll_hit;
  assign event_set[FLAG_NORESP] = noresp_hit;

  // Events outside the allowed set wait until the phase ends
  wire hard_clear = wr_proto;
  wire flag_clear = flags_read | hard_clear;
  wire [7:0] merged = phase_end ? pending : 8'h00;
  wire [7:0] flag_set = (event_set & allowed) | merged;
  wire [7:0] next_pending = (pending & ~{8{phase_end | hard_clear}})
    | (event_set & ~allowed);

  // Per-bit flag update, a new event wins over a clear
  logic [7:0] next_flags;
  for (genvar i = 0; i < 8; i++)
  begin : g_flag
    assign next_flags[i] = flag_set[i] | (flags[i] & ~flag_clear);
  end

  // Interrupt: phase ends always, idle events only through their enable
  wire idle_irq = ~in_phase & (|(event_set[5:0] & mask[5:0]));
  wire irq_set = phase_end | idle_irq;
  wire next_irq = irq_set | (irq_q & ~flag_clear);

  // Position capture: collisions in type A, errors elsewhere
  wire err_any = crc_error | parity_error | framing_error;
  wire pos_capture = iso_a ? coll_hit : err_any;
  wire [1:0] next_pos_high = pos_capture ? bit_position[9:8] :
    (mask_read ? 2'b00 : mask[7:6]);
  wire [7:0] next_colpos = pos_capture ? bit_position[7:0] :
    (colpos_read ? 8'h00 : colpos);
  wire [5:0] next_enables = wr_mask ? w_data_q[5:0] : mask[5:0];

  // Headroom: reserved code keeps what was chosen before
  wire head_valid = regulator[1:0] != HEADROOM_RESERVED;
  wire [1:0] next_headroom = (regulator[REG_AUTO] & head_valid) ?
    regulator[1:0] : headroom;

  // Outputs
  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign arready = ~rvalid;
  assign irq = irq_q;
  assign decoder_enable = ~tx_active;
  assign collision_position = {mask[7:6], colpos};
  assign regulator_auto = regulator[REG_AUTO];
  assign headroom_sel = headroom;
  assign manual_level = regulator[VSET_MSB:0];

  // Write address and data may arrive in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end
    else if (wr_go)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      w_held <= 1'b1;
      w_data_q <= wdata[7:0];
      w_lane0_q <= wstrb[0];
    end
    else if (wr_go)
      w_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Software-written control registers
  always_ff @(posedge aclk)
  begin
    if (dev_clear)
    begin
      protocol <= PROTOCOL_RST;
      noresp_wait <= NORESP_RST;
      regulator <= REGULATOR_RST;
      headroom <= HEADROOM_RST;
    end
    else
    begin
      if (wr_proto)
        protocol <= w_data_q;
      if (wr_noresp)
        noresp_wait <= w_data_q;
      if (wr_reg)
        regulator <= w_data_q;
      headroom <= next_headroom;
    end
  end

  // Flags, interrupt and collision position
  always_ff @(posedge aclk)
  begin
    if (dev_clear)
    begin
      flags <= FLAGS_RST;
      pending <= 8'h00;
      irq_q <= 1'b0;
      mask <= MASK_RST;
      colpos <= COLPOS_RST;
    end
    else
    begin
      flags <= next_flags;
      pending <= next_pending;
      irq_q <= next_irq;
      mask <= {next_pos_high, next_enables};
      colpos <= next_colpos;
    end
  end

  // Phase and FIFO edge history
  always_ff @(posedge aclk)
  begin
    if (dev_clear)
    begin
      tx_d <= 1'b0;
      rx_d <= 1'b0;
      fifo_cond_d <= 1'b0;
    end
    else
    begin
      tx_d <= tx_active;
      rx_d <= rx_active;
      fifo_cond_d <= fifo_cond;
    end
  end

  // Collision window opens on the first event, lasts one bit period;
  // the count saturates so a noisy window flags only once.
  always_ff @(posedge aclk)
  begin
    if (dev_clear || coll_win_done)
    begin
      coll_active <= 1'b0;
      coll_win <= 11'h000;
      coll_cnt <= 4'h0;
    end
    else if (coll_active)
    begin
      coll_win <= coll_win + 11'h001;
      if (collision_event && coll_cnt != 4'hf)
        coll_cnt <= coll_cnt + 4'h1;
    end
    else if (collision_event)
    begin
      coll_active <= 1'b1;
      coll_cnt <= 4'h1;
    end
  end

  // No-response watch from transmit end; wait of zero disables it
  always_comb
  begin
    next_nr_state = nr_state;
    case (nr_state)
      NR_IDLE:
        if (tx_end && noresp_wait != 8'h00)
          next_nr_state = NR_WAIT;
      NR_WAIT:
        if (nr_abort || noresp_hit)
          next_nr_state = NR_IDLE;
      default:
        next_nr_state = NR_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (dev_clear)
      nr_state <= NR_IDLE;
    else
      nr_state <= next_nr_state;
  end

  always_ff @(posedge aclk)
  begin
    if (dev_clear || nr_state != NR_WAIT)
    begin
      nr_step <= 16'h0000;
      nr_unit <= 8'h00;
    end
    else if (nr_step_done)
    begin
      nr_step <= 16'h0000;
      nr_unit <= nr_unit + 8'h01;
    end
    else
      nr_step <= nr_step + 16'h0001;
  end

endmodule

// file: verification/irq_status_collision_props.sv
// Checker for the interrupt status block, bound to its top module.
// Assumes one clock domain and the package register byte addresses.
module irq_status_collision_props
  import irq_status_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Inputs, plus the read address ready output
  input wire logic enable,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic crc_error,
  input wire logic parity_error,
  input wire logic framing_error,
  input wire logic collision_event,
  // Outputs
  input wire logic rvalid,
  input wire logic irq,
  input wire logic decoder_enable,
  input wire logic [9:0] collision_position,
  input wire logic regulator_auto,
  input wire logic [2:0] manual_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A capture in the same edge as a clear wins, so reads exclude events
  wire any_err = crc_error | parity_error | framing_error | collision_event;
  wire ar_take = arvalid && arready && !any_err;
  wire quiet = !tx_active && !rx_active;

  property p_decoder_off;
    tx_active |-> !decoder_enable;
  endproperty
  a_decoder_off: assert property (p_decoder_off)
    else $error("decoder left on during transmit");
  property p_tx_holds_irq;
    tx_active && !irq |=> !irq;
  endproperty
  a_tx_holds_irq: assert property (p_tx_holds_irq)
    else $error("interrupt raised inside transmit");
  property p_rx_holds_irq;
    rx_active && !irq |=> !irq;
  endproperty
  a_rx_holds_irq: assert property (p_rx_holds_irq)
    else $error("interrupt raised inside receive");
  property p_tx_end;
    $fell(tx_active) && enable |=> irq;
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("no interrupt after transmit end");
  property p_rx_end;
    $fell(rx_active) && enable |=> irq;
  endproperty
  a_rx_end: assert property (p_rx_end)
    else $error("no interrupt after receive end");
  property p_flags_read;
    ar_take && araddr == ADDR_FLAGS && quiet && $past(quiet) |=> !irq;
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("interrupt stays after flag read");
  property p_colpos_read;
    ar_take && araddr == ADDR_COLPOS |=> collision_position[7:0] == 8'h00;
  endproperty
  a_colpos_read: assert property (p_colpos_read)
    else $error("low position not cleared by read");
  property p_mask_read;
    ar_take && araddr == ADDR_MASK |=> collision_position[9:8] == 2'b00;
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("upper position not cleared by read");
  property p_enable_low;
    !enable |=> !irq && collision_position == 10'h000;
  endproperty
  a_enable_low: assert property (p_enable_low)
    else $error("enable low left state behind");
  property p_reset_vals;
    $rose(aresetn) |-> regulator_auto && manual_level == 3'h7;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("regulator reset value wrong");
  property p_read_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered in one cycle");
endmodule

bind irq_status_collision irq_status_collision_props u_props (
  .aclk, .aresetn, .enable, .tx_active, .rx_active, .arvalid, .arready,
  .araddr, .crc_error, .parity_error, .framing_error, .collision_event,
  .rvalid, .irq, .decoder_enable, .collision_position, .regulator_auto,
  .manual_level
);

// file: verification/link_events.sv
// Encoder, decoder and FIFO event source on the link side of the block.
// Assumes its tasks are called right after a rising clock edge.
module link_events
(
  // Clock
  input wire logic aclk,
  // Phases and one-cycle events
  output logic tx_active,
  output logic rx_active,
  output logic sof_detected,
  output logic crc_error,
  output logic parity_error,
  output logic framing_error,
  output logic collision_event,
  // Levels
  output logic [4:0] fifo_level,
  output logic [9:0] bit_position
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    tx_active = 1'b0;
    rx_active = 1'b0;
    {sof_detected, crc_error, parity_error} = 3'h0;
    {framing_error, collision_event} = 2'h0;
    // Mid level, so no FIFO event fires by accident
    fifo_level = 5'd6;
    bit_position = 10'h000;
  end

  task automatic set_level(input logic [4:0] v);
    fifo_level <= v;
  endtask

  task automatic phase(input logic rx, input int n);
    @(posedge aclk);
    tx_active <= !rx;
    rx_active <= rx;
    repeat (n) @(posedge aclk);
    tx_active <= 1'b0;
    rx_active <= 1'b0;
  endtask

  // Kinds: 0 frame start, 1 crc, 2 parity, 3 framing, 4 collision
  task automatic pulse(input int k, input logic [9:0] pos);
    @(posedge aclk);
    bit_position <= pos;
    sof_detected <= (k == 0);
    crc_error <= (k == 1);
    parity_error <= (k == 2);
    framing_error <= (k == 3);
    collision_event <= (k == 4);
    @(posedge aclk);
    bit_position <= ~pos;
    {sof_detected, crc_error, parity_error} <= 3'h0;
    {framing_error, collision_event} <= 2'h0;
  endtask
endmodule

// file: verification/test_irq_status_collision.sv
// Self-checking bench for the interrupt status block over AXI4-Lite.
// Assumes the link_events model and the bound checker.
module test_irq_status_collision
  import irq_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
  end
  localparam logic [7:0] REG_IN [5] = '{8'h86, 8'h80, 8'h81, 8'h87, 8'h05};
  localparam logic [1:0] HR_EXP [5] = '{2'b10, 2'b00, 2'b00, 2'b11, 2'b11};
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  logic aclk, aresetn, enable, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, dec_en, reg_auto;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r, headroom;
  logic [2:0] manual;
  logic [9:0] position, bit_pos;
  logic [4:0] level;
  logic [3:0] strb;
  logic [2:0] prot;
  logic tx, rx, sof, crc, par, frm, col;

  link_events link (.aclk, .tx_active(tx), .rx_active(rx),
    .sof_detected(sof), .crc_error(crc), .parity_error(par),
    .framing_error(frm), .collision_event(col), .fifo_level(level),
    .bit_position(bit_pos));

  // Short no-response step keeps the wait test brief
  irq_status_collision #(.NORESP_STEP_CYCLES(4)) dut (.aclk, .aresetn,
    .enable, .awvalid, .awready, .awaddr, .awprot(prot), .wvalid, .wready,
    .wdata, .wstrb(strb), .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .arprot(prot), .rvalid, .rready, .rdata, .rresp,
    .tx_active(tx), .rx_active(rx), .sof_detected(sof), .fifo_level(level),
    .crc_error(crc), .parity_error(par), .framing_error(frm),
    .collision_event(col), .bit_position(bit_pos), .irq,
    .decoder_enable(dec_en), .collision_position(position),
    .regulator_auto(reg_auto), .headroom_sel(headroom),
    .manual_level(manual));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic print_verdict();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      print_verdict();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Ready is sampled mid-cycle; it cannot change before the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ah, wh, da, dw, bh;
    logic [1:0] bs;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= a;
    wdata <= {24'h000000, v};
    while (!(da && dw))
    begin
      @(negedge aclk);
      ah = awready && !da;
      wh = wready && !dw;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      da = da | ah;
      dw = dw | wh;
    end
    do
    begin
      @(negedge aclk);
      bh = bvalid;
      bs = bresp;
      @(posedge aclk);
    end while (!bh);
    bready <= 1'b0;
    `CHK("write resp", RESP_OKAY, bs)
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v,
                    output logic [1:0] rs);
    logic h;
    @(posedge aclk);
    {arvalid, rready} <= 2'b11;
    araddr <= a;
    do
    begin
      @(negedge aclk);
      h = arready;
      @(posedge aclk);
    end while (!h);
    arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      h = rvalid;
      v = rdata[7:0];
      rs = rresp;
      @(posedge aclk);
    end while (!h);
    rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a, d, r);
    `CHK("read data", e, d)
    `CHK("read resp", RESP_OKAY, r)
  endtask

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    enable = 1'b1;
    {awaddr, araddr, wdata} = 48'h0;
    strb = 4'hf;
    prot = 3'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(ADDR_FLAGS, 8'h00);
    rdchk(ADDR_MASK, 8'h3e);
    rdchk(ADDR_COLPOS, 8'h00);
    rdchk(ADDR_REGULATOR, 8'h87);
    rd(8'h80, d, r);
    `CHK("unmapped resp", RESP_SLVERR, r)
    fork
      link.phase(1'b0, 8);
      begin
        idle(3);
        `CHK("decoder enable", 1'b0, dec_en)
        `CHK("irq in tx", 1'b0, irq)
        link.pulse(1, 10'h15a);
      end
    join
    idle(3);
    `CHK("irq after tx", 1'b1, irq)
    `CHK("position", 10'h15a, position)
    rdchk(ADDR_FLAGS, 8'h90);
    idle(0);
    `CHK("irq after read", 1'b0, irq)
    rdchk(ADDR_COLPOS, 8'h5a);
    rdchk(ADDR_MASK, 8'h7e);
    rdchk(ADDR_MASK, 8'h3e);
    link.set_level(5'd9);
    fork
      link.phase(1'b1, 8);
      begin
        link.pulse(0, 10'h000);
        idle(2);
        `CHK("irq in rx", 1'b0, irq)
      end
    join
    idle(3);
    `CHK("irq after rx", 1'b1, irq)
    rdchk(ADDR_FLAGS, 8'h60);
    link.set_level(5'd3);
    link.phase(1'b0, 4);
    link.set_level(5'd6);
    idle(3);
    wr(ADDR_PROTOCOL, 8'h80);
    rdchk(ADDR_FLAGS, 8'h00);
    link.pulse(1, 10'h000);
    idle(3);
    rdchk(ADDR_FLAGS, 8'h00);
    wr(ADDR_PROTOCOL, 8'h08);
    repeat (6) link.pulse(4, 10'h2a5);
    rdchk(ADDR_FLAGS, 8'h00);
    link.pulse(4, 10'h2a5);
    idle(3);
    `CHK("irq collision", 1'b1, irq)
    `CHK("position", 10'h2a5, position)
    rdchk(ADDR_FLAGS, 8'h02);
    rdchk(ADDR_MASK, 8'hbe);
    rdchk(ADDR_COLPOS, 8'ha5);
    for (int i = 0; i < 2; i++)
    begin
      link.pulse(2 + i, 10'h000);
      idle(3);
      `CHK("irq error", 1'b1, irq)
      rdchk(ADDR_FLAGS, 8'h08 >> i);
    end
    wr(ADDR_MASK, 8'h00);
    link.pulse(3, 10'h000);
    idle(3);
    `CHK("irq masked", 1'b0, irq)
    rdchk(ADDR_FLAGS, 8'h04);
    wr(ADDR_MASK, 8'h3f);
    wr(ADDR_NORESP, 8'h02);
    link.phase(1'b0, 2);
    idle(14);
    rdchk(ADDR_FLAGS, 8'h81);
    link.pulse(3, 10'h000);
    idle(3);
    @(posedge aclk);
    enable <= 1'b0;
    idle(2);
    `CHK("irq enable low", 1'b0, irq)
    @(posedge aclk);
    enable <= 1'b1;
    rdchk(ADDR_MASK, 8'h3e);
    rdchk(ADDR_FLAGS, 8'h00);
    // Write with lane 0 off must leave the enables alone
    strb <= 4'he;
    prot <= 3'h2;
    wr(ADDR_MASK, 8'h00);
    strb <= 4'hf;
    rdchk(ADDR_MASK, 8'h3e);
    wr(ADDR_PROTOCOL, 8'h28);
    repeat (7) link.pulse(4, 10'h0c3);
    rdchk(ADDR_FLAGS, 8'h00);
    link.pulse(4, 10'h0c3);
    idle(3);
    rdchk(ADDR_FLAGS, 8'h02);
    rdchk(ADDR_COLPOS, 8'hc3);
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_REGULATOR, REG_IN[i]);
      idle(2);
      `CHK("headroom", HR_EXP[i], headroom)
      `CHK("auto", REG_IN[i][7], reg_auto)
      `CHK("manual level", REG_IN[i][2:0], manual)
    end
    print_verdict();
  end
endmodule
